// >>> clock_and_stopwatch_timer.sv
// Purpose: clock timer and stopwatch timer with axi4-lite register access
// Assumes: single 125 MHz clock; software honours read-only-in-di advice
// Notes:   flags are read-to-clear; hardware set wins over read clear
//
// Contract
// - clock timer is a seven-bit counter advanced by the 256 Hz tick.
// - top four stages 16..2 Hz read-only, reset to zero.
// - three clock interrupt enables for 32, 8, 2 Hz, reset to zero.
// - clock flags set on tap falling edge regardless of enable.
// - clock flags clear on read, ignore writes, reset to zero.
// - writing 1 to clock clear zeroes counter; bit reads zero.
// - 2 Hz tap is exported as watchdog clock.
// - stopwatch is two cascaded bcd digits from an approx 100 Hz step.
// - low digit steps every 2 or 3 ticks giving 25 or 26 tick carries.
// - high digit sees 25 and 26 tick periods in 4:6 ratio.
// - digit roll from 9 to 0 sets matching stopwatch flag.
// - two stopwatch enables for 10 Hz and 1 Hz, reset to zero.
// - stopwatch flags clear on read, ignore writes; read with interrupts off.
// - both digits readable bcd, writes ignored, reset to zero.
// - writing 1 to stopwatch clear zeroes digits; bit reads zero.
// - run bit starts and stops counting, holds digits, resets to zero.
`timescale 1ns/1ns
`default_nettype none
module clock_and_stopwatch_timer #(
   parameter int unsigned TICK_DIV = tbc_pkg::TICK_DIV
) (
   input  wire logic                      clk_sys_in,
   input  wire logic                      rst_n_in,
   input  wire logic [tbc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [tbc_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   output logic                           irq_out,
   output logic                           wdt_clk_2hz_out
);
   typedef enum logic [1:0] {WR_IDLE = 2'b00, WR_RESP = 2'b01} wr_state_t;

   logic [31:0]         div_ff;
   logic                tick_ff;
   logic [6:0]          ctr_ff;
   logic [6:0]          nxt_ctr;
   logic [2:0]          clk_en_ff;
   logic [2:0]          clk_flg_ff;
   logic [1:0]          sw_en_ff;
   logic [1:0]          sw_flg_ff;
   logic                run_ff;
   logic                aw_got_ff;
   logic                w_got_ff;
   logic [tbc_pkg::ADDR_W-1:0] awaddr_ff;
   logic [31:0]         wdata_ff;
   logic [3:0]          wstrb_ff;
   wr_state_t           wr_state_ff;
   logic                wr_do;
   logic                wr_hit;
   logic [11:0]         wr_idx;
   logic [11:0]         rd_idx;
   logic                rd_do;
   logic                clk_clr;
   logic                sw_clr;
   logic [2:0]          clk_fall;
   logic                rd_clk_flg;
   logic                rd_sw_flg;
   logic [3:0]          rd_val;
   logic                rd_hit;
   tbc_pkg::sw_digits_t digits;
   tbc_pkg::sw_events_t sw_ev;

   // 256 Hz tick divider
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_ff  <= 32'h0;
         tick_ff <= 1'b0;
      end else if (div_ff == TICK_DIV - 1) begin
         div_ff  <= 32'h0;
         tick_ff <= 1'b1;
      end else begin
         div_ff  <= div_ff + 32'h1;
         tick_ff <= 1'b0;
      end
   end

   // write channel capture, either order
   assign wr_do  = aw_got_ff & w_got_ff & (wr_state_ff == WR_IDLE);
   assign wr_idx = awaddr_ff[tbc_pkg::ADDR_W-1:2];
   assign wr_hit = wr_do & wstrb_ff[0];

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aw_got_ff   <= 1'b0;
         w_got_ff    <= 1'b0;
         awaddr_ff   <= '0;
         wdata_ff    <= 32'h0;
         wstrb_ff    <= 4'h0;
         wr_state_ff <= WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= tbc_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         case (wr_state_ff)
            WR_IDLE: begin
               if (wr_do) begin
                  wr_state_ff  <= WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= (wr_idx == tbc_pkg::IDX_SW_EN ||
                                   wr_idx == tbc_pkg::IDX_CLK_EN ||
                                   wr_idx == tbc_pkg::IDX_CTRL ||
                                   wr_idx == tbc_pkg::IDX_CLK_VAL ||
                                   wr_idx == tbc_pkg::IDX_SW_LO ||
                                   wr_idx == tbc_pkg::IDX_SW_HI ||
                                   wr_idx == tbc_pkg::IDX_CLK_FLG ||
                                   wr_idx == tbc_pkg::IDX_SW_FLG) ?
                                  tbc_pkg::RESP_OKAY : tbc_pkg::RESP_SLVERR;
               end
            end
            WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state_ff  <= WR_IDLE;
                  s_axi_bvalid <= 1'b0;
                  aw_got_ff    <= 1'b0;
                  w_got_ff     <= 1'b0;
               end
            end
            default: wr_state_ff <= WR_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_got_ff & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready  <= ~w_got_ff & ~(s_axi_wvalid & s_axi_wready);
      end
   end

   // strobes: clears are write-only pulses, reads always return zero
   assign clk_clr = wr_hit & (wr_idx == tbc_pkg::IDX_CTRL) &
                    wdata_ff[tbc_pkg::CTRL_CLK_CLR];
   assign sw_clr  = wr_hit & (wr_idx == tbc_pkg::IDX_CTRL) &
                    wdata_ff[tbc_pkg::CTRL_SW_CLR];

   // clock timer
   assign nxt_ctr = clk_clr ? 7'h0 : (tick_ff ? ctr_ff + 7'h1 : ctr_ff);
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in)
         ctr_ff <= 7'h0;
      else
         ctr_ff <= nxt_ctr;
   end

   // a clear can drop a high tap, which counts as a falling edge
   assign clk_fall = {ctr_ff[tbc_pkg::TAP_2]  & ~nxt_ctr[tbc_pkg::TAP_2],
                      ctr_ff[tbc_pkg::TAP_8]  & ~nxt_ctr[tbc_pkg::TAP_8],
                      ctr_ff[tbc_pkg::TAP_32] & ~nxt_ctr[tbc_pkg::TAP_32]};

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in)
         wdt_clk_2hz_out <= 1'b0;
      else
         wdt_clk_2hz_out <= nxt_ctr[tbc_pkg::TAP_2];
   end

   // enables and run bit
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         clk_en_ff <= 3'h0;
         sw_en_ff  <= 2'h0;
         run_ff    <= 1'b0;
      end else if (wr_hit) begin
         if (wr_idx == tbc_pkg::IDX_CLK_EN)
            clk_en_ff <= wdata_ff[2:0];
         if (wr_idx == tbc_pkg::IDX_SW_EN)
            sw_en_ff <= wdata_ff[1:0];
         if (wr_idx == tbc_pkg::IDX_CTRL)
            run_ff <= wdata_ff[tbc_pkg::CTRL_SW_RUN];
      end
   end

   stopwatch_core u_sw (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .tick_in    (tick_ff),
      .run_in     (run_ff),
      .clear_in   (sw_clr),
      .digits_out (digits),
      .events_out (sw_ev)
   );

   // read channel
   assign rd_do = s_axi_arvalid & s_axi_arready;
   assign rd_idx = s_axi_araddr[tbc_pkg::ADDR_W-1:2];
   assign rd_clk_flg = rd_do & (rd_idx == tbc_pkg::IDX_CLK_FLG);
   assign rd_sw_flg  = rd_do & (rd_idx == tbc_pkg::IDX_SW_FLG);

   always_comb begin
      rd_hit = 1'b1;
      rd_val = 4'h0;
      case (rd_idx)
         tbc_pkg::IDX_CLK_VAL: rd_val = ctr_ff[6:tbc_pkg::TAP_LO];
         tbc_pkg::IDX_SW_LO:   rd_val = digits.hundredths_digit;
         tbc_pkg::IDX_SW_HI:   rd_val = digits.tenths_digit;
         tbc_pkg::IDX_SW_EN:   rd_val = {2'b00, sw_en_ff};
         tbc_pkg::IDX_CLK_EN:  rd_val = {1'b0, clk_en_ff};
         tbc_pkg::IDX_CLK_FLG: rd_val = {1'b0, clk_flg_ff};
         tbc_pkg::IDX_SW_FLG:  rd_val = {2'b00, sw_flg_ff};
         tbc_pkg::IDX_CTRL:    rd_val = {1'b0, run_ff, 2'b00};
         default:              rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= tbc_pkg::RESP_OKAY;
      end else begin
         if (rd_do) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {28'h0, rd_val};
            s_axi_rresp   <= rd_hit ? tbc_pkg::RESP_OKAY : tbc_pkg::RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
         end else if (!s_axi_rvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // flags: set wins over read clear so no event is lost
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         clk_flg_ff <= 3'h0;
         sw_flg_ff  <= 2'h0;
      end else begin
         clk_flg_ff <= (rd_clk_flg ? 3'h0 : clk_flg_ff) | clk_fall;
         sw_flg_ff  <= (rd_sw_flg ? 2'h0 : sw_flg_ff) |
                       {sw_ev.sw1_carry, sw_ev.sw10_carry};
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in)
         irq_out <= 1'b0;
      else
         irq_out <= |(clk_flg_ff & clk_en_ff) | |(sw_flg_ff & sw_en_ff);
   end

   // checks
   chk_flag_on_fall: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      clk_fall[0] |=> clk_flg_ff[0]) else $error("32 Hz flag not set");
   chk_flag_rd_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      rd_clk_flg && clk_fall == 3'h0 |=> clk_flg_ff == 3'h0)
      else $error("clock flags not cleared by read");
   chk_clr_zeroes: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      clk_clr |=> ctr_ff == 7'h0) else $error("clock clear failed");
   chk_tick_adv: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      tick_ff && !clk_clr |=> ctr_ff == $past(ctr_ff) + 7'h1)
      else $error("clock counter did not advance");
   chk_stop_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      !run_ff && !sw_clr |=> $stable(digits)) else $error("stopped stopwatch moved");
   chk_sw_bcd: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      digits.hundredths_digit <= 4'h9 && digits.tenths_digit <= 4'h9)
      else $error("digit not bcd");
   chk_sw_carry_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      sw_ev.sw10_carry |=> sw_flg_ff[0]) else $error("10 Hz flag missed");
   chk_irq_gate: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (clk_flg_ff & clk_en_ff) == 3'h0 && (sw_flg_ff & sw_en_ff) == 2'h0 |=> !irq_out)
      else $error("irq without enabled flag");
   chk_sw_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      sw_clr |=> digits == '0) else $error("stopwatch clear failed");
   cov_clk_fall2: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) clk_fall[2]);
   cov_sw_wrap: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) sw_ev.sw1_carry);
   cov_irq: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) irq_out);
endmodule
`default_nettype wire

// >>> stopwatch_core.sv
// Purpose: two-digit bcd stopwatch counting approximate 1/100 s steps
// Assumes: tick_in is a one-cycle 256 Hz enable on clk_sys_in
// Notes:   step pattern 2,3 ticks yields 25/26 tick carries in 4:6 mix
`timescale 1ns/1ns
`default_nettype none
module stopwatch_core (
   input  wire logic                clk_sys_in,
   input  wire logic                rst_n_in,
   input  wire logic                tick_in,
   input  wire logic                run_in,
   input  wire logic                clear_in,
   output var  tbc_pkg::sw_digits_t digits_out,
   output var  tbc_pkg::sw_events_t events_out
);
   logic [1:0] sub_ff;
   logic [3:0] lo_ff;
   logic [3:0] hi_ff;
   logic [1:0] step_len;
   logic       step;
   logic       lo_wrap;
   logic       hi_wrap;

   // within one tenth: odd hundredths take 3 ticks, even 2 (5 x 5 = 25);
   // six tenths get one extra tick on hundredths 8 -> 26 (6 of 10)
   always_comb begin
      if (lo_ff[0])
         step_len = 2'd3;
      else if (lo_ff == 4'h8 && hi_ff != 4'h0 && hi_ff != 4'h3 &&
               hi_ff != 4'h5 && hi_ff != 4'h8)
         step_len = 2'd3;
      else
         step_len = 2'd2;
   end
   // 10 tenths: 4 use 25 ticks (hi = 0,3,5,8), 6 use 26: total 256
   assign step    = run_in & tick_in & (sub_ff == step_len - 2'd1);
   assign lo_wrap = step & (lo_ff == tbc_pkg::BCD_MAX);
   assign hi_wrap = lo_wrap & (hi_ff == tbc_pkg::BCD_MAX);

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sub_ff <= 2'd0;
      end else if (clear_in || step) begin
         sub_ff <= 2'd0;
      end else if (run_in && tick_in) begin
         sub_ff <= sub_ff + 2'd1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lo_ff <= tbc_pkg::NIB_RST;
         hi_ff <= tbc_pkg::NIB_RST;
      end else if (clear_in) begin
         lo_ff <= tbc_pkg::NIB_RST;
         hi_ff <= tbc_pkg::NIB_RST;
      end else if (step) begin
         lo_ff <= lo_wrap ? tbc_pkg::NIB_RST : lo_ff + 4'h1;
         if (lo_wrap)
            hi_ff <= hi_wrap ? tbc_pkg::NIB_RST : hi_ff + 4'h1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         events_out <= '0;
      end else begin
         events_out.sw10_carry <= lo_wrap;
         events_out.sw1_carry  <= hi_wrap;
      end
   end

   assign digits_out.hundredths_digit = lo_ff;
   assign digits_out.tenths_digit     = hi_ff;
endmodule
`default_nettype wire

// >>> tb_clock_and_stopwatch_timer.sv
// Purpose: self-checking bench for the clock and stopwatch timer block
// Assumes: tick divide cut to 4 clocks, so 256 ticks span 1024 clocks
// Notes:   handshakes are judged at the falling edge to avoid update races
`timescale 1ns/1ns
`default_nettype none
module tb_clock_and_stopwatch_timer;
   localparam int unsigned DIV = 4;
   logic        clk_sys_in, rst_n_in;
   logic [13:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, irq_out, wdt_clk_2hz_out;
   int          fails, checks, cyc_cnt, t0;

   clock_and_stopwatch_timer #(.TICK_DIV(DIV)) u_dut (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .irq_out(irq_out),
      .wdt_clk_2hz_out(wdt_clk_2hz_out));

   initial begin
      clk_sys_in = 1'b0;
      forever #4 clk_sys_in = ~clk_sys_in;
   end

   always @(posedge clk_sys_in) begin
      cyc_cnt <= cyc_cnt + 1;
   end

   task automatic final_report;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask

   // pins are sampled mid-cycle, where the edge's updates have landed
   task automatic pin_chk(input logic exp, input string what);
      @(negedge clk_sys_in);
      chk({31'h0, (what == "irq") ? irq_out : wdt_clk_2hz_out}, {31'h0, exp}, what);
      @(posedge clk_sys_in);
   endtask

   task automatic axi_wr(input logic [11:0] idx, input logic [3:0] val,
                         input logic [3:0] strb, input logic [1:0] er);
      logic a, w, b;
      int   n;
      a = 1'b0; w = 1'b0; b = 1'b0; n = 0;
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= {28'h0, val};
      s_axi_wstrb   <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!b && n < 50) begin
         @(negedge clk_sys_in);
         a = s_axi_awvalid & s_axi_awready;
         w = s_axi_wvalid & s_axi_wready;
         b = s_axi_bvalid & s_axi_bready;
         resp = s_axi_bresp;
         @(posedge clk_sys_in);
         if (a) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
         n++;
      end
      if (!b) begin
         fails++;
         final_report();
      end
      chk({30'h0, resp}, {30'h0, er}, "write response");
   endtask

   task automatic axi_rd(input logic [11:0] idx, input logic [1:0] er);
      logic a, r;
      int   n;
      a = 1'b0; r = 1'b0; n = 0;
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!r && n < 50) begin
         @(negedge clk_sys_in);
         a = s_axi_arvalid & s_axi_arready;
         r = s_axi_rvalid & s_axi_rready;
         rd = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge clk_sys_in);
         if (a) s_axi_arvalid <= 1'b0;
         if (r) s_axi_rready <= 1'b0;
         n++;
      end
      if (!r) begin
         fails++;
         final_report();
      end
      chk({30'h0, resp}, {30'h0, er}, "read response");
   endtask

   task automatic rd_exp(input logic [11:0] idx, input logic [3:0] exp, input logic [3:0] mask);
      axi_rd(idx, tbc_pkg::RESP_OKAY);
      chk(rd & {28'h0, mask}, {28'h0, exp & mask}, "register read");
   endtask

   // flags first: the free-running clock timer sets them within 32 clocks
   task automatic reset_values;
      rd_exp(tbc_pkg::IDX_CLK_FLG, 4'h0, 4'hf);
      rd_exp(tbc_pkg::IDX_CLK_VAL, 4'h0, 4'hf);
      rd_exp(tbc_pkg::IDX_SW_LO, 4'h0, 4'hf);
      rd_exp(tbc_pkg::IDX_SW_HI, 4'h0, 4'hf);
      rd_exp(tbc_pkg::IDX_SW_EN, 4'h0, 4'hf);
      rd_exp(tbc_pkg::IDX_CLK_EN, 4'h0, 4'hf);
      rd_exp(tbc_pkg::IDX_SW_FLG, 4'h0, 4'hf);
      rd_exp(tbc_pkg::IDX_CTRL, 4'h0, 4'hf);
   endtask

   task automatic bus_refusals;
      axi_wr(12'h2e3, 4'h5, 4'hf, tbc_pkg::RESP_SLVERR);
      axi_rd(12'h2e3, tbc_pkg::RESP_SLVERR);
      chk(rd, 32'h0, "unmapped read data");
      axi_wr(tbc_pkg::IDX_CLK_EN, 4'h7, 4'h0, tbc_pkg::RESP_OKAY);
      rd_exp(tbc_pkg::IDX_CLK_EN, 4'h0, 4'hf);
      axi_wr(tbc_pkg::IDX_SW_LO, 4'h5, 4'hf, tbc_pkg::RESP_OKAY);
      rd_exp(tbc_pkg::IDX_SW_LO, 4'h0, 4'hf);
      axi_wr(tbc_pkg::IDX_SW_EN, 4'h3, 4'hf, tbc_pkg::RESP_OKAY);
      rd_exp(tbc_pkg::IDX_SW_EN, 4'h3, 4'h3);
      axi_wr(tbc_pkg::IDX_SW_EN, 4'h0, 4'hf, tbc_pkg::RESP_OKAY);
   endtask

   task automatic clock_timer;
      axi_wr(tbc_pkg::IDX_CTRL, 4'h8, 4'hf, tbc_pkg::RESP_OKAY);
      rd_exp(tbc_pkg::IDX_CLK_VAL, 4'h0, 4'hf);
      rd_exp(tbc_pkg::IDX_CTRL, 4'h0, 4'h8);
      axi_rd(tbc_pkg::IDX_CLK_FLG, tbc_pkg::RESP_OKAY);
      // 8 Hz and 2 Hz edges are far off, so a second read shows the clear
      rd_exp(tbc_pkg::IDX_CLK_FLG, 4'h0, 4'h6);
      cyc(290);
      pin_chk(1'b1, "wdt");
      rd_exp(tbc_pkg::IDX_CLK_VAL, 4'h8, 4'h8);
      cyc(300);
      pin_chk(1'b0, "irq");
      rd_exp(tbc_pkg::IDX_CLK_FLG, 4'h7, 4'hf);
      axi_wr(tbc_pkg::IDX_CLK_EN, 4'h4, 4'hf, tbc_pkg::RESP_OKAY);
      cyc(40);
      pin_chk(1'b0, "irq");
      axi_wr(tbc_pkg::IDX_CLK_EN, 4'h1, 4'hf, tbc_pkg::RESP_OKAY);
      rd_exp(tbc_pkg::IDX_CLK_EN, 4'h1, 4'hf);
      cyc(40);
      pin_chk(1'b1, "irq");
      axi_wr(tbc_pkg::IDX_CLK_EN, 4'h0, 4'hf, tbc_pkg::RESP_OKAY);
      cyc(2);
      pin_chk(1'b0, "irq");
   endtask

   // run window of exactly 1024 clocks holds 256 ticks, one full second
   task automatic stopwatch_second;
      axi_wr(tbc_pkg::IDX_CTRL, 4'h2, 4'hf, tbc_pkg::RESP_OKAY);
      axi_rd(tbc_pkg::IDX_SW_FLG, tbc_pkg::RESP_OKAY);
      cyc(3);
      t0 = cyc_cnt;
      axi_wr(tbc_pkg::IDX_CTRL, 4'h4, 4'hf, tbc_pkg::RESP_OKAY);
      rd_exp(tbc_pkg::IDX_CTRL, 4'h4, 4'hf);
      while (cyc_cnt < t0 + 120) @(posedge clk_sys_in);
      rd_exp(tbc_pkg::IDX_SW_FLG, 4'h1, 4'h3);
      rd_exp(tbc_pkg::IDX_SW_FLG, 4'h0, 4'h3);
      while (cyc_cnt < t0 + 1024) @(posedge clk_sys_in);
      axi_wr(tbc_pkg::IDX_CTRL, 4'h0, 4'hf, tbc_pkg::RESP_OKAY);
      rd_exp(tbc_pkg::IDX_SW_LO, 4'h0, 4'hf);
      rd_exp(tbc_pkg::IDX_SW_HI, 4'h0, 4'hf);
      pin_chk(1'b0, "irq");
      axi_wr(tbc_pkg::IDX_SW_EN, 4'h2, 4'hf, tbc_pkg::RESP_OKAY);
      cyc(3);
      pin_chk(1'b1, "irq");
      rd_exp(tbc_pkg::IDX_SW_FLG, 4'h3, 4'h3);
      cyc(3);
      pin_chk(1'b0, "irq");
      axi_wr(tbc_pkg::IDX_SW_EN, 4'h0, 4'hf, tbc_pkg::RESP_OKAY);
   endtask

   task automatic stopwatch_hold_clear;
      axi_wr(tbc_pkg::IDX_CTRL, 4'h4, 4'hf, tbc_pkg::RESP_OKAY);
      cyc(120);
      axi_wr(tbc_pkg::IDX_CTRL, 4'h0, 4'hf, tbc_pkg::RESP_OKAY);
      rd_exp(tbc_pkg::IDX_SW_HI, 4'h1, 4'hf);
      cyc(200);
      rd_exp(tbc_pkg::IDX_SW_HI, 4'h1, 4'hf);
      axi_wr(tbc_pkg::IDX_CTRL, 4'h4, 4'hf, tbc_pkg::RESP_OKAY);
      cyc(120);
      axi_wr(tbc_pkg::IDX_CTRL, 4'h0, 4'hf, tbc_pkg::RESP_OKAY);
      rd_exp(tbc_pkg::IDX_SW_HI, 4'h2, 4'hf);
      axi_wr(tbc_pkg::IDX_CTRL, 4'h2, 4'hf, tbc_pkg::RESP_OKAY);
      cyc(60);
      rd_exp(tbc_pkg::IDX_SW_LO, 4'h0, 4'hf);
      rd_exp(tbc_pkg::IDX_SW_HI, 4'h0, 4'hf);
      axi_wr(tbc_pkg::IDX_CTRL, 4'h4, 4'hf, tbc_pkg::RESP_OKAY);
      cyc(120);
      axi_wr(tbc_pkg::IDX_CTRL, 4'he, 4'hf, tbc_pkg::RESP_OKAY);
      rd_exp(tbc_pkg::IDX_CTRL, 4'h4, 4'hf);
      cyc(40);
      axi_wr(tbc_pkg::IDX_CTRL, 4'h0, 4'hf, tbc_pkg::RESP_OKAY);
      rd_exp(tbc_pkg::IDX_SW_HI, 4'h0, 4'hf);
   endtask

   initial begin
      fails = 0; checks = 0; cyc_cnt = 0; rst_n_in = 1'b0;
      s_axi_awaddr = '0; s_axi_awvalid = 1'b0; s_axi_wdata = '0; s_axi_wstrb = '0;
      s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = '0;
      s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
      cyc(5);
      rst_n_in <= 1'b1;
      cyc(2);
      reset_values();
      bus_refusals();
      clock_timer();
      stopwatch_second();
      stopwatch_hold_clear();
      final_report();
   end
endmodule
`default_nettype wire

// >>> tbc_pkg.sv
// Purpose: shared constants and types for the clock and stopwatch timer block
// Assumes: 125 MHz system clock, axi4-lite register access, 32-bit data
// Notes:   register offsets are byte addresses of 4 times the printed index
package tbc_pkg;

   localparam int unsigned CLK_HZ        = 125000000;
   localparam int unsigned TICK_HZ       = 256;
   // default tick divide; long counts shortened via top parameter
   localparam int unsigned TICK_DIV      = CLK_HZ / TICK_HZ;

   // printed register indices
   localparam logic [11:0] IDX_CLK_VAL   = 12'h2e0;
   localparam logic [11:0] IDX_SW_LO     = 12'h2e1;
   localparam logic [11:0] IDX_SW_HI     = 12'h2e2;
   localparam logic [11:0] IDX_SW_EN     = 12'h2e6;
   localparam logic [11:0] IDX_CLK_EN    = 12'h2e8;
   localparam logic [11:0] IDX_CLK_FLG   = 12'h2e9;
   localparam logic [11:0] IDX_SW_FLG    = 12'h2ea;
   localparam logic [11:0] IDX_CTRL      = 12'h2ee;
   localparam int unsigned ADDR_W        = 14;

   // control register fields
   localparam int unsigned CTRL_CLK_CLR  = 3;
   localparam int unsigned CTRL_SW_RUN   = 2;
   localparam int unsigned CTRL_SW_CLR   = 1;

   // clock counter tap positions (bit0 = 128 Hz)
   localparam int unsigned TAP_32        = 2;
   localparam int unsigned TAP_8         = 4;
   localparam int unsigned TAP_2         = 6;
   localparam int unsigned TAP_LO        = 3;

   localparam logic [3:0]  BCD_MAX       = 4'h9;
   localparam logic [3:0]  NIB_RST       = 4'h0;
   localparam logic [1:0]  RESP_OKAY     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR   = 2'b10;

   typedef struct packed {
      logic [3:0] hundredths_digit;
      logic [3:0] tenths_digit;
   } sw_digits_t;

   typedef struct packed {
      logic       sw10_carry;
      logic       sw1_carry;
   } sw_events_t;

endpackage
